// ---- common/cpc_map.vh ----
// register map, reset values and field positions of the camera pipeline control bank
// assumes word registers of 16 bits reached by an 8-bit register pointer
`ifndef CPC_MAP_VH
`define CPC_MAP_VH

`define CPC_SLAVE_ADDR      7'h7B
`define CPC_OFS_FRAME_RATE  8'h03
`define CPC_OFS_GAIN_GAMMA  8'h04
`define CPC_OFS_BW_POINT    8'h05
`define CPC_OFS_ROI_COL     8'h06
`define CPC_OFS_ROI_ROW     8'h07
`define CPC_OFS_VIDEO_CTRL  8'h08

// frame rate register held at an arbitrary 30 frames per second
`define CPC_RST_FRAME_RATE  16'h001E
`define CPC_RST_GAIN_GAMMA  16'h1000
`define CPC_RST_BW_POINT    16'h0000
`define CPC_RST_ROI_COL     16'h0000
`define CPC_RST_ROI_ROW     16'h0000
`define CPC_RST_VIDEO_CTRL  16'h0000

`define CPC_PIXREP_COUNT    2'h3
`define CPC_FR_RATE_MSB     5
`define CPC_FR_REP_LSB      6
`define CPC_GG_SKIP_LSB     11
`define CPC_GG_MAXG_LSB     6
`define CPC_GG_USRG_LSB     1
`define CPC_GG_OVR_BIT      0
`define CPC_VC_TAG_BIT      15
`define CPC_VC_HYST_BIT     14
`define CPC_VC_STALL_BIT    13
`define CPC_VC_DARK_BIT     12
`define CPC_VC_SHSTR_BIT    11
`define CPC_VC_SHEN_BIT     10
`define CPC_VC_FPNG_BIT     9
`define CPC_VC_FPNO_BIT     8
`define CPC_VC_FFFPN_BIT    7
`define CPC_VC_GAIN_BIT     6
`define CPC_VC_WP_BIT       5
`define CPC_VC_BP_BIT       4
`define CPC_VC_DEF_BIT      3
`define CPC_VC_SYNC_BIT     2
`define CPC_VC_NTSC_BIT     1

`endif

// ---- logic/cpc_regs.v ----
// camera pipeline control register bank with its serial two-wire slave port
// assumes scl and sda arrive from pins; frame_start and syncs come from mclk logic
`timescale 1ns/100ps
`include "cpc_map.vh"

module cpc_regs (
  input  wire        mclk,                      // 20 MHz system clock
  input  wire        rst_n,                     // asynchronous reset, active low
  input  wire        scl_in,                    // serial clock pin level
  input  wire        sda_in,                    // serial data pin level
  output reg         sda_out,                   // serial data drive value
  output reg         sda_oe,                    // serial data drive enable
  input  wire        remap_selected,            // switch: gain on and linear remap chosen
  input  wire        frame_start,               // one-cycle pulse at each frame start
  input  wire [4:0]  auto_gamma_code,           // gamma chosen by automatic control
  input  wire        hsync_in,                  // internal horizontal sync, active high
  input  wire        vsync_in,                  // internal vertical sync, active high
  output reg         hsync_out,                 // port horizontal sync
  output reg         vsync_out,                 // port vertical sync
  output reg  [1:0]  pixel_replace_select,      // replacement mode of active video
  output reg         counting_pattern_enable,   // counting pattern replaces video
  output reg  [5:0]  frame_rate,                // frames per second
  output reg  [3:0]  gamma_skip,                // frames between gamma updates
  output reg         gamma_update,              // pulse: automatic gamma may update
  output reg  [4:0]  max_gamma,                 // gamma cap valid for current frame
  output reg  [4:0]  gamma_code,                // gamma code in use
  output reg  [13:0] black_target_count,        // target black pixels
  output reg  [15:0] white_target_count,        // target white pixels
  output reg  [11:0] window_end_column,         // window end column
  output reg  [11:0] window_start_column,       // window start column
  output reg  [9:0]  window_end_row,            // window end row
  output reg  [9:0]  window_start_row,          // window start row
  output reg         frame_tag_row_enable,      // tag first row with parameters
  output reg         integration_hysteresis,    // suppress sub-row changes
  output reg         exposure_freeze_untransmitted, // hold exposure on skipped frames
  output reg         dark_correct_enable,       // dark current correction on
  output reg         sharpen_enable,            // sharpening filter on
  output reg         sharpen_strong_select,     // stronger sharpening
  output reg         column_gain_correct_enable,   // column gain correction on
  output reg         column_offset_correct_enable, // column offset correction on
  output reg         column_noise_full_frame_test, // full frame noise collection
  output reg         gain_stages_enable,        // gain stages active
  output reg         white_point_active,        // remap gain active
  output reg         black_point_active,        // remap offset active
  output reg         defect_filter_enable,      // defect filter on
  output reg         analog_test_pattern_enable // analog test pattern on
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_RX   = 3'd3;
  localparam ST_RACK = 3'd4;
  localparam ST_TX   = 3'd5;
  localparam ST_TACK = 3'd6;

  reg  [15:0] frame_rate_q;
  reg  [15:0] gain_gamma_q;
  reg  [15:0] bw_point_q;
  reg  [15:0] roi_col_q;
  reg  [15:0] roi_row_q;
  reg  [15:0] video_ctrl_q;

  reg  [1:0]  scl_sync_q;
  reg  [1:0]  sda_sync_q;
  reg  [1:0]  remap_sync_q;
  reg         scl_prev_q;
  reg         sda_prev_q;
  reg  [2:0]  state_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  tx_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  hi_byte_q;
  reg  [1:0]  phase_q;
  reg         read_q;
  reg         tx_low_q;
  reg         nack_q;
  reg  [3:0]  skip_cnt_q;
  reg         wr_stb_q;
  reg  [15:0] wr_data_q;
  reg  [15:0] rd_word;

  wire scl_s     = scl_sync_q[1];
  wire sda_s     = sda_sync_q[1];
  wire scl_rise  = scl_s & ~scl_prev_q;
  wire scl_fall  = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // pins cross into mclk; the first stage feeds only the second
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q   <= 2'h3;
      sda_sync_q   <= 2'h3;
      remap_sync_q <= 2'h0;
      scl_prev_q   <= 1'b1;
      sda_prev_q   <= 1'b1;
    end else begin
      scl_sync_q   <= {scl_sync_q[0], scl_in};
      sda_sync_q   <= {sda_sync_q[0], sda_in};
      remap_sync_q <= {remap_sync_q[0], remap_selected};
      scl_prev_q   <= scl_s;
      sda_prev_q   <= sda_s;
    end
  end

  // unmapped pointers read as zero; reserved bits are stored whole
  always @* begin
    case (ptr_q)
      `CPC_OFS_FRAME_RATE: rd_word = frame_rate_q;
      `CPC_OFS_GAIN_GAMMA: rd_word = gain_gamma_q;
      `CPC_OFS_BW_POINT:   rd_word = bw_point_q;
      `CPC_OFS_ROI_COL:    rd_word = roi_col_q;
      `CPC_OFS_ROI_ROW:    rd_word = roi_row_q;
      `CPC_OFS_VIDEO_CTRL: rd_word = video_ctrl_q;
      default:             rd_word = 16'h0000;
    endcase
  end

  // serial slave: pointer byte, then high and low data bytes per word,
  // pointer advancing after each whole word in either direction
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      hi_byte_q <= 8'h00;
      phase_q   <= 2'h0;
      read_q    <= 1'b0;
      tx_low_q  <= 1'b0;
      nack_q    <= 1'b0;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_data_q <= 16'h0000;
    end else begin
      wr_stb_q <= 1'b0;
      if (start_det) begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        phase_q   <= 2'h0;
        sda_oe    <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          ST_ADDR, ST_RX: begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          ST_TX: bit_cnt_q <= bit_cnt_q + 4'h1;
          // pointer steps during the ack bit so the next word can launch at its fall
          ST_TACK: begin
            nack_q <= sda_s;
            if (tx_low_q)
              ptr_q <= ptr_q + 8'h01;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (shift_q[7:1] == `CPC_SLAVE_ADDR) begin
                read_q  <= shift_q[0];
                sda_out <= 1'b0;
                sda_oe  <= 1'b1;
                state_q <= ST_AACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_cnt_q <= 4'h0;
            if (read_q) begin
              tx_q     <= rd_word[15:8];
              tx_low_q <= 1'b0;
              sda_out  <= rd_word[15];
              sda_oe   <= 1'b1;
              state_q  <= ST_TX;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= ST_RX;
            end
          end
          ST_RX: begin
            if (bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              sda_out   <= 1'b0;
              sda_oe    <= 1'b1;
              state_q   <= ST_RACK;
              case (phase_q)
                2'h0: begin
                  ptr_q   <= shift_q;
                  phase_q <= 2'h1;
                end
                2'h1: begin
                  hi_byte_q <= shift_q;
                  phase_q   <= 2'h2;
                end
                default: begin
                  wr_data_q <= {hi_byte_q, shift_q};
                  wr_stb_q  <= 1'b1;
                  phase_q <= 2'h1;
                end
              endcase
            end
          end
          ST_RACK: begin
            sda_oe  <= 1'b0;
            state_q <= ST_RX;
          end
          ST_TX: begin
            if (bit_cnt_q == 4'h8) begin
              sda_oe  <= 1'b0;
              state_q <= ST_TACK;
            end else begin
              sda_out <= tx_q[3'd7 - bit_cnt_q[2:0]];
            end
          end
          ST_TACK: begin
            bit_cnt_q <= 4'h0;
            if (nack_q) begin
              state_q <= ST_IDLE;
            end else if (tx_low_q) begin
              tx_q     <= rd_word[15:8];
              tx_low_q <= 1'b0;
              state_q  <= ST_TX;
              sda_oe   <= 1'b1;
              sda_out  <= rd_word[15];
            end else begin
              tx_q     <= rd_word[7:0];
              tx_low_q <= 1'b1;
              sda_out  <= rd_word[7];
              sda_oe   <= 1'b1;
              state_q  <= ST_TX;
            end
          end
          default: ;
        endcase
      end
      if (wr_stb_q)
        ptr_q <= ptr_q + 8'h01;
    end
  end

  // register storage; every bit written is kept for read-back
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_rate_q <= `CPC_RST_FRAME_RATE;
      gain_gamma_q <= `CPC_RST_GAIN_GAMMA;
      bw_point_q   <= `CPC_RST_BW_POINT;
      roi_col_q    <= `CPC_RST_ROI_COL;
      roi_row_q    <= `CPC_RST_ROI_ROW;
      video_ctrl_q <= `CPC_RST_VIDEO_CTRL;
    end else if (wr_stb_q) begin
      case (ptr_q)
        `CPC_OFS_FRAME_RATE: frame_rate_q <= wr_data_q;
        `CPC_OFS_GAIN_GAMMA: gain_gamma_q <= wr_data_q;
        `CPC_OFS_BW_POINT:   bw_point_q   <= wr_data_q;
        `CPC_OFS_ROI_COL:    roi_col_q    <= wr_data_q;
        `CPC_OFS_ROI_ROW:    roi_row_q    <= wr_data_q;
        `CPC_OFS_VIDEO_CTRL: video_ctrl_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  // frame-paced gamma: cap latched per frame, updates every skip frames
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      max_gamma    <= 5'h00;
      skip_cnt_q   <= 4'h0;
      gamma_update <= 1'b0;
    end else begin
      gamma_update <= 1'b0;
      if (frame_start) begin
        max_gamma <= gain_gamma_q[`CPC_GG_MAXG_LSB +: 5];
        // a skip of zero is treated as one, updating every frame
        if (skip_cnt_q + 4'h1 >= gain_gamma_q[`CPC_GG_SKIP_LSB +: 4]) begin
          skip_cnt_q   <= 4'h0;
          gamma_update <= 1'b1;
        end else begin
          skip_cnt_q <= skip_cnt_q + 4'h1;
        end
      end
    end
  end

  // decoded controls, each refreshed every cycle from the stored words
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hsync_out                     <= 1'b0;
      vsync_out                     <= 1'b0;
      pixel_replace_select          <= 2'h0;
      counting_pattern_enable       <= 1'b0;
      frame_rate                    <= 6'h00;
      gamma_skip                    <= 4'h0;
      gamma_code                    <= 5'h00;
      black_target_count            <= 14'h0000;
      white_target_count            <= 16'h0000;
      window_end_column             <= 12'h000;
      window_start_column           <= 12'h000;
      window_end_row                <= 10'h000;
      window_start_row              <= 10'h000;
      frame_tag_row_enable          <= 1'b0;
      integration_hysteresis        <= 1'b0;
      exposure_freeze_untransmitted <= 1'b0;
      dark_correct_enable           <= 1'b0;
      sharpen_enable                <= 1'b0;
      sharpen_strong_select         <= 1'b0;
      column_gain_correct_enable    <= 1'b0;
      column_offset_correct_enable  <= 1'b0;
      column_noise_full_frame_test  <= 1'b0;
      gain_stages_enable            <= 1'b0;
      white_point_active            <= 1'b0;
      black_point_active            <= 1'b0;
      defect_filter_enable          <= 1'b0;
      analog_test_pattern_enable    <= 1'b0;
    end else begin
      hsync_out <= hsync_in ^ video_ctrl_q[`CPC_VC_SYNC_BIT];
      vsync_out <= vsync_in ^ video_ctrl_q[`CPC_VC_SYNC_BIT];
      pixel_replace_select <= frame_rate_q[`CPC_FR_REP_LSB +: 2];
      counting_pattern_enable <=
        (frame_rate_q[`CPC_FR_REP_LSB +: 2] == `CPC_PIXREP_COUNT);
      frame_rate <= frame_rate_q[`CPC_FR_RATE_MSB:0];
      gamma_skip <= gain_gamma_q[`CPC_GG_SKIP_LSB +: 4];
      // user gamma bypasses frame pacing, so it may change mid-frame
      gamma_code <= gain_gamma_q[`CPC_GG_OVR_BIT] ?
                    gain_gamma_q[`CPC_GG_USRG_LSB +: 5] : auto_gamma_code;
      // targets read zero unless the remap path is live
      if (remap_sync_q[1] && video_ctrl_q[`CPC_VC_GAIN_BIT]) begin
        black_target_count <= {bw_point_q[15:8], 6'h00};
        white_target_count <= {bw_point_q[7:0], 8'h00};
      end else begin
        black_target_count <= 14'h0000;
        white_target_count <= 16'h0000;
      end
      // a byte field plus three zero bits cannot reach the top column bit
      window_end_column   <= {1'b0, roi_col_q[15:8], 3'h0};
      window_start_column <= {1'b0, roi_col_q[7:0], 3'h0};
      window_end_row      <= {roi_row_q[15:8], 2'h0};
      window_start_row    <= {roi_row_q[7:0], 2'h0};
      frame_tag_row_enable          <= video_ctrl_q[`CPC_VC_TAG_BIT];
      integration_hysteresis        <= video_ctrl_q[`CPC_VC_HYST_BIT];
      exposure_freeze_untransmitted <= video_ctrl_q[`CPC_VC_STALL_BIT];
      dark_correct_enable           <= video_ctrl_q[`CPC_VC_DARK_BIT];
      sharpen_enable                <= video_ctrl_q[`CPC_VC_SHEN_BIT];
      sharpen_strong_select         <= video_ctrl_q[`CPC_VC_SHSTR_BIT];
      column_gain_correct_enable    <= video_ctrl_q[`CPC_VC_FPNG_BIT];
      column_offset_correct_enable  <= video_ctrl_q[`CPC_VC_FPNO_BIT];
      column_noise_full_frame_test  <= video_ctrl_q[`CPC_VC_FFFPN_BIT];
      gain_stages_enable            <= video_ctrl_q[`CPC_VC_GAIN_BIT];
      // gain bypass also silences remap gain and offset
      white_point_active <= video_ctrl_q[`CPC_VC_GAIN_BIT] &
                            video_ctrl_q[`CPC_VC_WP_BIT] & remap_sync_q[1];
      black_point_active <= video_ctrl_q[`CPC_VC_GAIN_BIT] &
                            video_ctrl_q[`CPC_VC_WP_BIT] &
                            video_ctrl_q[`CPC_VC_BP_BIT] & remap_sync_q[1];
      defect_filter_enable       <= video_ctrl_q[`CPC_VC_DEF_BIT];
      analog_test_pattern_enable <= video_ctrl_q[`CPC_VC_NTSC_BIT];
    end
  end

endmodule

// ---- sim/cpc_regs_assertions.sv ----
// port assertions and covers for the camera pipeline control bank
// assumes the single mclk domain with the asynchronous reset rst_n
`timescale 1ns/100ps
module cpc_regs_assertions (
  input wire        mclk,                    // clock
  input wire        rst_n,                   // reset, active low
  input wire        frame_start,             // frame pulse
  input wire [1:0]  pixel_replace_select,    // replace mode
  input wire        counting_pattern_enable, // pattern on
  input wire        gamma_update,            // update pulse
  input wire [4:0]  max_gamma,               // gamma cap
  input wire [13:0] black_target_count,      // black target
  input wire [15:0] white_target_count,      // white target
  input wire [11:0] window_end_column,       // column end
  input wire [11:0] window_start_column,     // column start
  input wire [9:0]  window_end_row,          // row end
  input wire [9:0]  window_start_row,        // row start
  input wire        gain_stages_enable,      // gain on
  input wire        white_point_active,      // remap gain on
  input wire        black_point_active       // remap offset on
);
  default clocking cpc_cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_pattern;
    counting_pattern_enable == (pixel_replace_select == 2'h3);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern flag wrong");
  property p_gated;
    (|black_target_count || |white_target_count) |-> gain_stages_enable;
  endproperty
  a_gated: assert property (p_gated) else $error("target without gain");
  property p_steps;
    black_target_count[5:0] == 6'h00 && white_target_count[7:0] == 8'h00;
  endproperty
  a_steps: assert property (p_steps) else $error("target step wrong");
  property p_window;
    (window_end_column[2:0] | window_start_column[2:0]) == 3'h0 &&
      (window_end_row[1:0] | window_start_row[1:0]) == 2'h0;
  endproperty
  a_window: assert property (p_window) else $error("window low bits set");
  property p_bp_wp;
    black_point_active |-> white_point_active;
  endproperty
  a_bp_wp: assert property (p_bp_wp) else $error("offset without remap");
  property p_wp_gain;
    white_point_active |-> gain_stages_enable;
  endproperty
  a_wp_gain: assert property (p_wp_gain) else $error("remap while bypassed");
  // the cap may only move just after a frame boundary
  property p_cap;
    !$past(frame_start) && !$past(frame_start, 2) |-> $stable(max_gamma);
  endproperty
  a_cap: assert property (p_cap) else $error("cap moved mid frame");
  property p_update;
    gamma_update |-> $past(frame_start) || $past(frame_start, 2);
  endproperty
  a_update: assert property (p_update) else $error("update off frame");
  c_pattern: cover property (counting_pattern_enable);
  c_update: cover property (gamma_update);
  c_black: cover property (black_point_active);
endmodule

// ---- sim/cpc_host.sv ----
// host model on the two-wire control port: one word written or read per transfer
// assumes the bench resolves the pulled-up wire and returns its level on sda
`timescale 1ns/100ps
module cpc_host (
  input  wire  mclk,  // paces the bit phases
  input  wire  sda,   // resolved data wire
  output logic scl,   // serial clock, idle high
  output logic sda_m  // host drive, 1 releases the wire
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // five cycles a phase keeps every scl phase above the slave's minimum
  task automatic lv(input logic s, input logic c);
    sda_m = s;
    scl = c;
    repeat (5) @(negedge mclk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    lv(b, 1'b0);
    lv(b, 1'b1);
    r = sda;
    lv(b, 1'b0);
  endtask
  task automatic byte_x(input logic [7:0] d, input logic nak, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(nak, r);
    ack = !r;
  endtask
  task automatic start_c();
    lv(1'b1, 1'b0);
    lv(1'b1, 1'b1);
    lv(1'b0, 1'b1);
    lv(1'b0, 1'b0);
  endtask
  // high byte first; a read acks the high byte and refuses the low one
  task automatic xfer(input logic [6:0] adr, input logic [7:0] p, input logic rd,
                      input logic [15:0] d, output logic [15:0] q, output logic ok);
    logic [3:0] a;
    start_c();
    byte_x({adr, 1'b0}, 1'b1, q[7:0], a[0]);
    byte_x(p, 1'b1, q[7:0], a[1]);
    if (rd) begin
      start_c();
      byte_x({adr, 1'b1}, 1'b1, q[7:0], a[1]);
    end
    byte_x(rd ? 8'hFF : d[15:8], !rd, q[15:8], a[2]);
    byte_x(rd ? 8'hFF : d[7:0], 1'b1, q[7:0], a[3]);
    lv(1'b0, 1'b0);
    lv(1'b0, 1'b1);
    lv(1'b1, 1'b1);
    ok = &a;
  endtask
endmodule

// ---- sim/test_cpc_regs.sv ----
// self-checking bench: table of register writes and read-backs, then edge cases
// assumes the host model on the two-wire port; the bench drives the frame side
`timescale 1ns/100ps
module test_cpc_regs;
  typedef struct packed {logic [7:0] p; logic [15:0] d;} cpc_row_t;
  logic        mclk, rst_n, remap, fs, hs, vs, ok;
  logic [4:0]  agc;
  logic [15:0] q, vc, upd_cnt;
  int          err_count, total_checks;
  wire         scl, sda_m, sda_out, sda_oe;
  wire         sda = sda_m & ~(sda_oe & ~sda_out); // pulled-up open-drain wire
  cpc_row_t    rows [10] = '{'{8'h03, 16'h00C5}, '{8'h03, 16'hA47F}, '{8'h04, 16'h7FFF},
    '{8'h04, 16'h0006}, '{8'h08, 16'hA583}, '{8'h05, 16'hFF01}, '{8'h08, 16'h5A7C},
    '{8'h05, 16'hFF01}, '{8'h06, 16'hC901}, '{8'h07, 16'hFF03}};
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  cpc_host host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
  cpc_regs dut_u (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .remap_selected(remap), .frame_start(fs), .auto_gamma_code(agc),
    .hsync_in(hs), .vsync_in(vs), .hsync_out(), .vsync_out(), .pixel_replace_select(),
    .counting_pattern_enable(), .frame_rate(), .gamma_skip(), .gamma_update(), .max_gamma(),
    .gamma_code(), .black_target_count(), .white_target_count(), .window_end_column(),
    .window_start_column(), .window_end_row(), .window_start_row(), .frame_tag_row_enable(),
    .integration_hysteresis(), .exposure_freeze_untransmitted(), .dark_correct_enable(),
    .sharpen_enable(), .sharpen_strong_select(), .column_gain_correct_enable(),
    .column_offset_correct_enable(), .column_noise_full_frame_test(), .gain_stages_enable(),
    .white_point_active(), .black_point_active(), .defect_filter_enable(),
    .analog_test_pattern_enable());
  always @(posedge mclk) upd_cnt <= upd_cnt + dut_u.gamma_update;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_row(input logic [7:0] p, input logic [15:0] d);
    logic gate;
    gate = vc[6] & remap;
    case (p)
      8'h03: begin
        chk("rate", d[5:0], dut_u.frame_rate);
        chk("pattern", {d[7:6], d[7:6] == 2'h3},
          {dut_u.pixel_replace_select, dut_u.counting_pattern_enable});
      end
      8'h04: begin
        chk("skip", d[14:11], dut_u.gamma_skip);
        chk("gamma", d[0] ? d[5:1] : agc, dut_u.gamma_code);
      end
      8'h05: begin
        chk("black", gate ? {d[15:8], 6'h00} : 14'h0000,
          dut_u.black_target_count);
        chk("white", gate ? {d[7:0], 8'h00} : 16'h0000,
          dut_u.white_target_count);
      end
      8'h06: chk("cols", {d[15:8], d[7:0]},
        {dut_u.window_end_column[10:3], dut_u.window_start_column[10:3]});
      8'h07: chk("rows", {d[15:8], d[7:0]},
        {dut_u.window_end_row[9:2], dut_u.window_start_row[9:2]});
      default: begin
        chk("ctl_hi", d[15:12], {dut_u.frame_tag_row_enable,
          dut_u.integration_hysteresis, dut_u.exposure_freeze_untransmitted,
          dut_u.dark_correct_enable});
        chk("ctl_lo", {d[11:6], d[3], d[1]},
          {dut_u.sharpen_strong_select, dut_u.sharpen_enable,
          dut_u.column_gain_correct_enable, dut_u.column_offset_correct_enable,
          dut_u.column_noise_full_frame_test, dut_u.gain_stages_enable,
          dut_u.defect_filter_enable, dut_u.analog_test_pattern_enable});
        chk("remap", {d[6] & d[5] & remap, &d[6:4] & remap},
          {dut_u.white_point_active, dut_u.black_point_active});
        chk("sync", {~d[2], d[2]}, {dut_u.hsync_out, dut_u.vsync_out});
      end
    endcase
  endtask
  task automatic frame();
    fs = 1'b1;
    @(negedge mclk);
    fs = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    err_count++;
    end_sim();
  end
  initial begin
    {rst_n, fs, vs, vc, upd_cnt} = '0;
    remap = 1'b1;
    hs = 1'b1;
    agc = 5'h11;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk("rate_rst", 16'h001E, dut_u.frame_rate);
    host_u.xfer(7'h7B, 8'h04, 1'b1, 16'h0000, q, ok);
    chk("gg_rst", 16'h1000, q);
    foreach (rows[i]) begin
      host_u.xfer(7'h7B, rows[i].p, 1'b0, rows[i].d, q, ok);
      chk("ack", 16'h0001, ok);
      vc = rows[i].p == 8'h08 ? rows[i].d : vc;
      check_row(rows[i].p, rows[i].d);
      host_u.xfer(7'h7B, rows[i].p, 1'b1, 16'h0000, q, ok);
      chk("readback", rows[i].d, q);
    end
    // skip 3, cap 10, user gamma 4 with override
    host_u.xfer(7'h7B, 8'h04, 1'b0, 16'h1A89, q, ok);
    chk("cap_held", 16'h0000, dut_u.max_gamma);
    chk("user_now", 16'h0004, dut_u.gamma_code);
    repeat (6) frame();
    chk("cap_new", 16'h000A, dut_u.max_gamma);
    chk("updates", 16'h0002, upd_cnt);
    remap = 1'b0;
    repeat (5) @(negedge mclk);
    chk("remap_off", 16'h0000, dut_u.white_target_count | dut_u.black_target_count);
    host_u.xfer(7'h7A, 8'h08, 1'b0, 16'h0000, q, ok);
    chk("no_ack", 16'h0000, ok);
    host_u.xfer(7'h7B, 8'h08, 1'b1, 16'h0000, q, ok);
    chk("kept", 16'h5A7C, q);
    host_u.xfer(7'h7B, 8'h09, 1'b0, 16'hBEEF, q, ok);
    host_u.xfer(7'h7B, 8'h09, 1'b1, 16'h0000, q, ok);
    chk("unmapped", 16'h0000, q);
    end_sim();
  end
endmodule
bind cpc_regs cpc_regs_assertions chk_u (.mclk, .rst_n, .frame_start, .pixel_replace_select,
  .counting_pattern_enable, .gamma_update, .max_gamma, .black_target_count,
  .white_target_count, .window_end_column, .window_start_column, .window_end_row,
  .window_start_row, .gain_stages_enable, .white_point_active, .black_point_active);
